// ===== core/cscs_pin_sync.sv
// two-flop synchroniser for pins arriving from outside core_clk
// assumes inputs are quasi-static across a few core_clk cycles
`timescale 1ns/1ps
module cscs_pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // first stage feeds only the second
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      // idle-high reset level, so release shows no false line edge
      meta_reg <= '1;
      sync_reg <= '1;
    end
    else
    begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
    end
  end

  assign pin_sync = sync_reg;

endmodule : cscs_pin_sync

// ===== core/cscs_pkg.sv
// constants and carrier types for the two-wire control port slave
// assumes the register space sits outside, on core_clk, one-cycle read latency
// Summary of operation
// R1: address 0x30; low three bits from pins
// R2: 7-bit address, two-byte sub-address, byte data
// R3: pointer advances by one per data byte
// R4: sub-address write, restart, then read
// R5: direct read returns last used pointer
// R6: master ack continues; nack and stop end
// R7: write: address, two sub-address bytes, data
// R8: sequential write stores until stop
// R9: restart only after sub-address acknowledged; the code restarts address reception on a start in any state
// R10: msb first; ack low on ninth clock
package cscs_pkg;

  localparam logic [6:0] CSCS_DEV_ADDR_DEFAULT = 7'h30;
  localparam int         CSCS_SEL_BITS         = 3;
  localparam int         CSCS_SUB_WIDTH        = 16;
  localparam int         CSCS_DATA_WIDTH       = 8;
  localparam logic [3:0] CSCS_BYTE_BITS        = 4'h8;
  localparam logic [15:0] CSCS_PTR_RESET       = 16'h0000;
  localparam logic [15:0] CSCS_PTR_STEP        = 16'h0001;

  typedef enum logic [3:0] {
    CSCS_ST_IDLE,
    CSCS_ST_ADDR,
    CSCS_ST_ADDR_ACK,
    CSCS_ST_SUB_HI,
    CSCS_ST_SUB_HI_ACK,
    CSCS_ST_SUB_LO,
    CSCS_ST_SUB_LO_ACK,
    CSCS_ST_WDATA,
    CSCS_ST_WDATA_ACK,
    CSCS_ST_RDATA,
    CSCS_ST_RDATA_ACK
  } cscs_state_t;

  typedef struct packed {
    logic [CSCS_SUB_WIDTH-1:0]  addr;
    logic [CSCS_DATA_WIDTH-1:0] data;
  } cscs_wr_t;

endpackage : cscs_pkg

// ===== core/cscs_slave.sv
// two-wire control port slave: bus pins in, register read/write requests out
// assumes the serial clock is far slower than core_clk and the register
// space answers a read request with data on the following cycle
`timescale 1ns/1ps
module cscs_slave (
  input  wire logic                                core_clk,
  input  wire logic                                reset_n,
  input  wire logic                                ctrl_serial_clock,
  input  wire logic                                ctrl_serial_data_in,
  output logic                                     ctrl_serial_data_out,
  output logic                                     ctrl_serial_data_oe,
  input  wire logic [cscs_pkg::CSCS_SEL_BITS-1:0]  bus_addr_select_pins,
  input  wire logic                                addr_select_enable,
  output logic                                     wr_req,
  output cscs_pkg::cscs_wr_t                       wr_cmd,
  output logic                                     rd_req,
  output logic [cscs_pkg::CSCS_SUB_WIDTH-1:0]      rd_addr,
  input  wire logic [cscs_pkg::CSCS_DATA_WIDTH-1:0] rd_data,
  output logic                                     busy
);

  logic [1:0]                              line_sync;
  logic [cscs_pkg::CSCS_SEL_BITS-1:0]      sel_sync;
  logic                                    scl_s;
  logic                                    sda_s;
  logic                                    scl_prev_reg;
  logic                                    sda_prev_reg;
  logic                                    scl_rise;
  logic                                    scl_fall;
  logic                                    start_seen;
  logic                                    stop_seen;
  logic [6:0]                              dev_addr;

  cscs_pkg::cscs_state_t                   state_reg;
  cscs_pkg::cscs_state_t                   state_next;
  logic [3:0]                              bit_reg;
  logic [3:0]                              bit_next;
  logic [7:0]                              shift_reg;
  logic [7:0]                              shift_next;
  logic [7:0]                              sub_hi_reg;
  logic [7:0]                              sub_hi_next;
  logic [15:0]                             ptr_reg;
  logic [15:0]                             ptr_next;
  logic                                    rw_reg;
  logic                                    rw_next;
  logic                                    mack_reg;
  logic                                    mack_next;
  logic                                    oe_reg;
  logic                                    oe_next;
  logic                                    wr_req_reg;
  logic                                    wr_req_next;
  cscs_pkg::cscs_wr_t                      wr_reg;
  cscs_pkg::cscs_wr_t                      wr_next;
  logic                                    rd_req_reg;
  logic                                    rd_req_next;
  logic                                    rd_dly_reg;
  logic [7:0]                              rd_hold_reg;
  logic [7:0]                              rd_hold_next;

  cscs_pin_sync #(.WIDTH (2)) u_line_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .pin_in   ({ctrl_serial_clock, ctrl_serial_data_in}),
    .pin_sync (line_sync)
  );

  cscs_pin_sync #(.WIDTH (cscs_pkg::CSCS_SEL_BITS)) u_sel_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .pin_in   (bus_addr_select_pins),
    .pin_sync (sel_sync)
  );

  assign scl_s = line_sync[1];
  assign sda_s = line_sync[0];

  // edges and bus conditions, flagged in the same core_clk as the synchroniser output changes
  assign scl_rise   = scl_s && !scl_prev_reg;
  assign scl_fall   = !scl_s && scl_prev_reg;
  assign start_seen = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
  assign stop_seen  = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;

  // select pins replace only the low bits of the default address [R1]
  assign dev_addr = addr_select_enable ?
    {cscs_pkg::CSCS_DEV_ADDR_DEFAULT[6:cscs_pkg::CSCS_SEL_BITS], sel_sync} :
    cscs_pkg::CSCS_DEV_ADDR_DEFAULT;

  function automatic logic [15:0] ptr_advance(input logic [15:0] ptr);
    return ptr + cscs_pkg::CSCS_PTR_STEP;
  endfunction : ptr_advance

  always_comb
  begin
    state_next   = state_reg;
    bit_next     = bit_reg;
    shift_next   = shift_reg;
    sub_hi_next  = sub_hi_reg;
    ptr_next     = ptr_reg;
    rw_next      = rw_reg;
    mack_next    = mack_reg;
    oe_next      = oe_reg;
    wr_next      = wr_reg;
    wr_req_next  = 1'b0;
    rd_req_next  = 1'b0;
    rd_hold_next = rd_dly_reg ? rd_data : rd_hold_reg;
    // a start, repeated or not, always restarts address reception [R4] [R9]
    if (start_seen)
    begin
      state_next = cscs_pkg::CSCS_ST_ADDR;
      bit_next   = '0;
      oe_next    = 1'b0;
    end
    else if (stop_seen)
    begin
      // stop ends any write run or read run [R6] [R8]
      state_next = cscs_pkg::CSCS_ST_IDLE;
      oe_next    = 1'b0;
    end
    else
    begin
      case (state_reg)
        cscs_pkg::CSCS_ST_ADDR,
        cscs_pkg::CSCS_ST_SUB_HI,
        cscs_pkg::CSCS_ST_SUB_LO,
        cscs_pkg::CSCS_ST_WDATA:
        begin
          if (scl_rise && bit_reg != cscs_pkg::CSCS_BYTE_BITS)
          begin
            shift_next = {shift_reg[6:0], sda_s}; // msb first [R10]
            bit_next   = bit_reg + 4'h1;
          end
          else if (scl_fall && bit_reg == cscs_pkg::CSCS_BYTE_BITS)
          begin
            bit_next = '0;
            oe_next  = 1'b1; // pull low through the ninth clock [R10]
            case (state_reg)
              cscs_pkg::CSCS_ST_ADDR:
              begin
                if (shift_reg[7:1] == dev_addr) // [R1] [R2]
                begin
                  state_next  = cscs_pkg::CSCS_ST_ADDR_ACK;
                  rw_next     = shift_reg[0];
                  // read with no sub-address uses the held pointer [R5]
                  rd_req_next = shift_reg[0];
                end
                else
                begin
                  state_next = cscs_pkg::CSCS_ST_IDLE;
                  oe_next    = 1'b0;
                end
              end
              cscs_pkg::CSCS_ST_SUB_HI:
              begin
                sub_hi_next = shift_reg; // high sub-address byte first [R2] [R7]
                state_next  = cscs_pkg::CSCS_ST_SUB_HI_ACK;
              end
              cscs_pkg::CSCS_ST_SUB_LO:
              begin
                ptr_next   = {sub_hi_reg, shift_reg}; // [R2] [R4]
                state_next = cscs_pkg::CSCS_ST_SUB_LO_ACK;
              end
              default:
              begin
                wr_next     = '{addr: ptr_reg, data: shift_reg}; // [R7]
                wr_req_next = 1'b1;
                ptr_next    = ptr_advance(ptr_reg); // [R3] [R8]
                state_next  = cscs_pkg::CSCS_ST_WDATA_ACK;
              end
            endcase
          end
        end
        cscs_pkg::CSCS_ST_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            if (rw_reg)
            begin
              // device drives data after acking its address [R4]
              state_next = cscs_pkg::CSCS_ST_RDATA;
              shift_next = rd_hold_reg;
              oe_next    = !rd_hold_reg[7];
            end
            else
            begin
              state_next = cscs_pkg::CSCS_ST_SUB_HI;
              oe_next    = 1'b0;
            end
          end
        end
        cscs_pkg::CSCS_ST_SUB_HI_ACK,
        cscs_pkg::CSCS_ST_SUB_LO_ACK,
        cscs_pkg::CSCS_ST_WDATA_ACK:
        begin
          // any number of data bytes may follow [R8]
          if (scl_fall)
          begin
            state_next = (state_reg == cscs_pkg::CSCS_ST_SUB_HI_ACK) ?
              cscs_pkg::CSCS_ST_SUB_LO : cscs_pkg::CSCS_ST_WDATA;
            oe_next    = 1'b0;
          end
        end
        cscs_pkg::CSCS_ST_RDATA:
        begin
          if (scl_rise)
            bit_next = bit_reg + 4'h1;
          else if (scl_fall)
          begin
            if (bit_reg == cscs_pkg::CSCS_BYTE_BITS)
            begin
              bit_next    = '0;
              oe_next     = 1'b0; // master owns the ninth clock
              state_next  = cscs_pkg::CSCS_ST_RDATA_ACK;
              ptr_next    = ptr_advance(ptr_reg); // [R3]
              rd_req_next = 1'b1; // prefetch next byte early
            end
            else
            begin
              shift_next = {shift_reg[6:0], 1'b0}; // [R10]
              oe_next    = !shift_reg[6];
            end
          end
        end
        cscs_pkg::CSCS_ST_RDATA_ACK:
        begin
          if (scl_rise)
            mack_next = !sda_s;
          else if (scl_fall)
          begin
            if (mack_reg) // ack continues at next sub-address [R6]
            begin
              state_next = cscs_pkg::CSCS_ST_RDATA;
              shift_next = rd_hold_reg;
              oe_next    = !rd_hold_reg[7];
            end
            else // nack: read ends, straight back to idle [R6]
              state_next = cscs_pkg::CSCS_ST_IDLE;
          end
        end
        default:
          state_next = cscs_pkg::CSCS_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      state_reg    <= cscs_pkg::CSCS_ST_IDLE;
      bit_reg      <= '0;
      shift_reg    <= '0;
      sub_hi_reg   <= '0;
      ptr_reg      <= cscs_pkg::CSCS_PTR_RESET;
      rw_reg       <= 1'b0;
      mack_reg     <= 1'b0;
      oe_reg       <= 1'b0;
      wr_req_reg   <= 1'b0;
      wr_reg       <= '0;
      rd_req_reg   <= 1'b0;
      rd_dly_reg   <= 1'b0;
      rd_hold_reg  <= '0;
    end
    else
    begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
      state_reg    <= state_next;
      bit_reg      <= bit_next;
      shift_reg    <= shift_next;
      sub_hi_reg   <= sub_hi_next;
      ptr_reg      <= ptr_next;
      rw_reg       <= rw_next;
      mack_reg     <= mack_next;
      oe_reg       <= oe_next;
      wr_req_reg   <= wr_req_next;
      wr_reg       <= wr_next;
      rd_req_reg   <= rd_req_next;
      rd_dly_reg   <= rd_req_reg;
      rd_hold_reg  <= rd_hold_next;
    end
  end

  // open-drain: only ever pulls low
  assign ctrl_serial_data_out = 1'b0;
  assign ctrl_serial_data_oe  = oe_reg;
  assign wr_req               = wr_req_reg;
  assign wr_cmd               = wr_reg;
  assign rd_req               = rd_req_reg;
  assign rd_addr              = ptr_reg;
  assign busy                 = state_reg != cscs_pkg::CSCS_ST_IDLE;

endmodule : cscs_slave

// ===== sim/camera_serial_control_slave_tb_top.sv
// bench for the control port slave: host model, register space, scenarios
// assumes the register space answers a read request on the next cycle
`timescale 1ns/1ps
module camera_serial_control_slave_tb_top;
  logic               core_clk, reset_n, sel_en, wr_req, rd_req, busy;
  logic               oe, d_out, scl, sda_rel, sda;
  logic [2:0]         sel_pins;
  logic [7:0]         rd_data;
  logic [15:0]        rd_addr;
  cscs_pkg::cscs_wr_t wr_cmd;
  logic [7:0]         mem [0:65535];
  int                 bad_count = 0;
  int                 tests_run = 0;
  // pull-up wins unless someone pulls low
  assign sda = sda_rel & (oe ? d_out : 1'b1);
  cscs_host_model host (.scl(scl), .sda_rel(sda_rel), .sda(sda));
  cscs_slave dut (.core_clk(core_clk), .reset_n(reset_n), .ctrl_serial_clock(scl),
    .ctrl_serial_data_in(sda), .ctrl_serial_data_out(d_out), .ctrl_serial_data_oe(oe),
    .bus_addr_select_pins(sel_pins), .addr_select_enable(sel_en), .wr_req(wr_req),
    .wr_cmd(wr_cmd), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .busy(busy));
  always @(posedge core_clk)
  begin
    if (wr_req) mem[wr_cmd.addr] <= wr_cmd.data;
    if (rd_req) rd_data <= mem[rd_addr];
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic put(input logic [7:0] b, input logic exp_ack);
    logic a;
    host.send_byte(b, a);
    chk("ack", 16'(a), 16'(exp_ack));
  endtask : put
  task automatic get(input logic more, input logic [7:0] exp);
    logic [7:0] b;
    host.recv_byte(more, b);
    chk("rdata", 16'(b), 16'(exp));
  endtask : get
  task automatic t_write_seq;
    host.start_cond();
    put(8'h60, 1'b1);
    put(8'h12, 1'b1);
    put(8'hfe, 1'b1);
    for (int i = 0; i < 3; i++)
      put(8'ha1 + 8'(i) * 8'h11, 1'b1);
    host.stop_cond();
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < 3; i++)
      chk("mem", 16'(mem[16'h12fe + 16'(i)]), 16'(8'ha1 + 8'(i) * 8'h11));
    chk("busy_end", 16'(busy), 16'h0000);
  endtask : t_write_seq
  task automatic t_read_random;
    host.start_cond();
    put(8'h60, 1'b1);
    put(8'h12, 1'b1);
    put(8'hff, 1'b1);
    host.start_cond();
    put(8'h61, 1'b1);
    get(1'b1, 8'hb2);
    get(1'b0, 8'hc3);
    host.stop_cond();
  endtask : t_read_random
  task automatic t_read_current;
    host.start_cond();
    chk("busy_run", 16'(busy), 16'h0001);
    put(8'h61, 1'b1);
    get(1'b1, 8'h01 ^ 8'h5a);
    get(1'b0, 8'h02 ^ 8'h5a);
    host.stop_cond();
  endtask : t_read_current
  task automatic t_addr_select;
    host.start_cond();
    put(8'h62, 1'b0);
    host.stop_cond();
    @(posedge core_clk);
    #1 sel_pins = 3'b101;
    sel_en = 1'b1;
    repeat (6) @(posedge core_clk);
    host.start_cond();
    put(8'h60, 1'b0);
    host.stop_cond();
    host.start_cond();
    put(8'h6a, 1'b1);
    put(8'h00, 1'b1);
    put(8'h40, 1'b1);
    put(8'h77, 1'b1);
    host.stop_cond();
    repeat (4) @(posedge core_clk);
    chk("mem_sel", 16'(mem[16'h0040]), 16'h0077);
  endtask : t_addr_select
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial
  begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
  initial
  begin
    reset_n = 1'b0;
    sel_en = 1'b0;
    sel_pins = 3'b000;
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'(i) ^ 8'h5a;
    repeat (16) @(posedge core_clk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge core_clk);
    chk("busy_rst", 16'(busy), 16'h0000);
    chk("ptr_rst", rd_addr, cscs_pkg::CSCS_PTR_RESET);
    t_write_seq();
    t_read_random();
    t_read_current();
    t_addr_select();
    tally_and_finish();
  end
endmodule : camera_serial_control_slave_tb_top

// ===== sim/cscs_host_model.sv
// two-wire bus master model: clock and open-drain data release
// assumes the bench resolves the wire with a pull-up; 64 ns bit period
`timescale 1ns/1ps
module cscs_host_model (
  output logic      scl,
  output logic      sda_rel,
  input  wire logic sda
);
  localparam int Q = 16;
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // also the repeated start; clock stands high only between frames
  task automatic start_cond;
    sda_rel = 1'b1;
    #Q scl = 1'b1;
    #Q sda_rel = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask : start_cond
  task automatic stop_cond;
    sda_rel = 1'b0;
    #Q scl = 1'b1;
    #Q sda_rel = 1'b1;
    #Q;
  endtask : stop_cond
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sda_rel = b[i];
      #Q scl = 1'b1;
      #(2*Q) scl = 1'b0;
      #Q;
    end
    sda_rel = 1'b1;
    #Q scl = 1'b1;
    #Q ack = ~sda;
    #Q scl = 1'b0;
    #Q;
  endtask : send_byte
  task automatic recv_byte(input logic more, output logic [7:0] b);
    sda_rel = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      #Q scl = 1'b1;
      #Q b = {b[6:0], sda};
      #Q scl = 1'b0;
      #Q;
    end
    sda_rel = ~more;
    #Q scl = 1'b1;
    #(2*Q) scl = 1'b0;
    #Q sda_rel = 1'b1;
  endtask : recv_byte
endmodule : cscs_host_model

// ===== sim/cscs_slave_chk.sv
// assertions on the control port slave's bus pins and register pulses
// assumes a single core_clk domain; bound onto every cscs_slave
`timescale 1ns/1ps
module cscs_slave_chk (
  input wire logic                                 core_clk,
  input wire logic                                 reset_n,
  input wire logic                                 ctrl_serial_clock,
  input wire logic                                 ctrl_serial_data_in,
  input wire logic                                 ctrl_serial_data_out,
  input wire logic                                 ctrl_serial_data_oe,
  input wire logic [cscs_pkg::CSCS_SEL_BITS-1:0]   bus_addr_select_pins,
  input wire logic                                 addr_select_enable,
  input wire logic                                 wr_req,
  input wire cscs_pkg::cscs_wr_t                   wr_cmd,
  input wire logic                                 rd_req,
  input wire logic [cscs_pkg::CSCS_SUB_WIDTH-1:0]  rd_addr,
  input wire logic [cscs_pkg::CSCS_DATA_WIDTH-1:0] rd_data,
  input wire logic                                 busy
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  a_drive_low_only: assert property (ctrl_serial_data_out == 1'b0)
    else $error("data out not held low");
  a_wr_one_pulse: assert property (wr_req |=> !wr_req)
    else $error("write request longer than one cycle");
  a_wr_ptr_step: assert property (wr_req |=> rd_addr == $past(wr_cmd.addr) + 16'h0001)
    else $error("pointer not advanced by one after write");
  a_wr_ack_held: assert property (wr_req |-> ctrl_serial_data_oe [*3])
    else $error("write byte not acknowledged");
  a_rd_one_pulse: assert property (rd_req |=> !rd_req)
    else $error("read request longer than one cycle");
  a_rd_addr_hold: assert property (rd_req |=> $stable(rd_addr))
    else $error("read address moved during fetch");
  a_oe_clock_low: assert property ($changed(ctrl_serial_data_oe) |-> !ctrl_serial_clock)
    else $error("data line changed while clock high");
  a_oe_when_busy: assert property (ctrl_serial_data_oe |-> busy)
    else $error("data line driven while idle");
  a_wr_cmd_hold: assert property (wr_req |=> $stable(wr_cmd))
    else $error("write command moved after request");
  a_rd_when_busy: assert property (rd_req |-> busy)
    else $error("read request while idle");
endmodule : cscs_slave_chk

bind cscs_slave cscs_slave_chk u_chk (.core_clk(core_clk), .reset_n(reset_n),
  .ctrl_serial_clock(ctrl_serial_clock), .ctrl_serial_data_in(ctrl_serial_data_in),
  .ctrl_serial_data_out(ctrl_serial_data_out), .ctrl_serial_data_oe(ctrl_serial_data_oe),
  .bus_addr_select_pins(bus_addr_select_pins), .addr_select_enable(addr_select_enable),
  .wr_req(wr_req), .wr_cmd(wr_cmd), .rd_req(rd_req), .rd_addr(rd_addr),
  .rd_data(rd_data), .busy(busy));
